/* File: tccb_pkg.sv */
// Purpose: constants and types for the timer capture/buffer control block
// Assumes: one register word at byte 0x00, a second of own choosing at 0x04
// Notes: shared by the control module and its testbench
package tccb_pkg;
  localparam logic [7:0] TCCB_OFF_CTRL = 8'h00;
  localparam logic [7:0] TCCB_OFF_STAT = 8'h04;
  localparam logic [31:0] TCCB_CTRL_RESET = 32'h0000_0000;
  localparam int TCCB_BIT_SOFTWARE_RESET_TRIGGER = 0;
  localparam int TCCB_BIT_ENABLE = 1;
  localparam int TCCB_BIT_AUTO_LOCK_ENABLE = 11;
  localparam int TCCB_BIT_CAPTEN0 = 16;
  localparam int TCCB_BIT_COPEN0 = 20;
  // bits applied at once, not enable protected: auto_lock_enable, capture_channel_enable
  localparam logic [31:0] TCCB_DIRECT_MASK = 32'h0003_0800;
  // writable enable-protected bits (prescaler, mode, pin_capture_select, misc)
  localparam logic [31:0] TCCB_PROT_MASK = 32'h0030_07fc;
  localparam logic [15:0] TCCB_VAL_RESET = 16'h0000;
  localparam int TCCB_SYNC_CYCLES = 2;

  typedef struct packed {
    logic ovf;
    logic unf;
    logic retrig;
    logic upd;
  } tccb_evt_t;

  typedef struct packed {
    logic [15:0] active_period_value;
    logic [15:0] cc1;
    logic [15:0] cc0;
  } tccb_vals_t;
endpackage

/* File: tccb_ctrl.sv */
// Purpose: channel mode, capture source and buffered-update control of a timer
// Assumes: single clock, Avalon-MM slave with waitrequest, counter events on same clock
// Notes: waitrequest is low one cycle after a request appears
// Functional notes
// - lock clear: buffered compare and period copied to active on update
// - lock set: active values held on update, buffers stay pending
// - per channel, pin capture select: 0 event trigger, 1 pin trigger
// - per channel, capture enable: 0 compare channel, 1 capture channel
// - capture enable bits written directly, no synchronisation delay
// - auto lock sets update lock on overflow, underflow or retrigger
// - auto lock bit written directly, no synchronisation delay
// - update lock ignored while any capture channel is enabled
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module tccb_ctrl (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire tccb_pkg::tccb_evt_t evt_i,
  input wire logic lock_set_i,
  input wire logic lock_clr_i,
  input wire tccb_pkg::tccb_vals_t buf_i,
  input wire logic [1:0] capt_evt_i,
  input wire logic [1:0] capt_pin_i,
  output tccb_pkg::tccb_vals_t active_o,
  output logic update_lock_flag_o,
  output logic [1:0] capture_channel_enable_o,
  output logic [1:0] capt_trig_o,
  output logic enable_o
);
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] pend_q;
  logic pend_vld_q;
  logic [$clog2(tccb_pkg::TCCB_SYNC_CYCLES+1)-1:0] sync_cnt_q;
  logic lock_q;
  logic lock_d;
  logic ack_q;
  logic wait_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] trig_q;
  tccb_pkg::tccb_vals_t act_q;
  logic [31:0] rdata_q;

  wire req = (avs_read_i | avs_write_i) & ~ack_q;
  wire sel_ctrl = avs_address_i == tccb_pkg::TCCB_OFF_CTRL;
  wire sel_stat = avs_address_i == tccb_pkg::TCCB_OFF_STAT;
  wire wr_ctrl = req & avs_write_i & sel_ctrl;
  wire enabled = ctrl_q[tccb_pkg::TCCB_BIT_ENABLE];
  wire software_reset_trigger = wr_ctrl & avs_writedata_i[tccb_pkg::TCCB_BIT_SOFTWARE_RESET_TRIGGER];
  wire [1:0] capture_channel_enable = ctrl_q[tccb_pkg::TCCB_BIT_CAPTEN0 +: 2];
  wire [1:0] pin_capture_select = ctrl_q[tccb_pkg::TCCB_BIT_COPEN0 +: 2];
  wire auto_lock_enable = ctrl_q[tccb_pkg::TCCB_BIT_AUTO_LOCK_ENABLE];
  wire cap_mode = |capture_channel_enable;
  wire lock_eff = lock_q & ~cap_mode;
  wire do_update = evt_i.upd & ~lock_eff;
  wire auto_set = auto_lock_enable & (evt_i.ovf | evt_i.unf | evt_i.retrig);
  wire sync_busy = pend_vld_q;
  wire [31:0] enable_bit = 32'h0000_0001 << tccb_pkg::TCCB_BIT_ENABLE;
  // protected fields are dropped once enabled; enable itself always writable
  wire [31:0] prot_ok = enabled ? 32'h0000_0000 : tccb_pkg::TCCB_PROT_MASK;
  wire [31:0] sync_mask = prot_ok | enable_bit;
  wire [31:0] sync_land = (ctrl_q & ~sync_mask) | (pend_q & sync_mask);
  wire sync_done = pend_vld_q && sync_cnt_q == ($bits(sync_cnt_q))'(tccb_pkg::TCCB_SYNC_CYCLES);

  // direct bits take effect the cycle after the write; others wait the sync delay
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (sync_done)
      ctrl_d = (sync_land & ~tccb_pkg::TCCB_DIRECT_MASK) | (ctrl_q & tccb_pkg::TCCB_DIRECT_MASK);
    if (wr_ctrl)
      ctrl_d = (ctrl_d & ~tccb_pkg::TCCB_DIRECT_MASK)
             | (avs_writedata_i & tccb_pkg::TCCB_DIRECT_MASK);
    if (software_reset_trigger)
      ctrl_d = tccb_pkg::TCCB_CTRL_RESET;
  end

  // set wins over clear so an event in the clear cycle is kept
  always_comb
  begin
    lock_d = lock_q;
    if (lock_clr_i)
      lock_d = 1'b0;
    if (lock_set_i | auto_set)
      lock_d = 1'b1;
    if (software_reset_trigger)
      lock_d = 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= tccb_pkg::TCCB_CTRL_RESET;
      pend_q <= tccb_pkg::TCCB_CTRL_RESET;
      pend_vld_q <= 1'b0;
      sync_cnt_q <= '0;
      lock_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      lock_q <= lock_d;
      if (wr_ctrl & ~software_reset_trigger)
      begin
        pend_q <= avs_writedata_i;
        pend_vld_q <= 1'b1;
        sync_cnt_q <= '0;
      end
      else if (sync_done | software_reset_trigger)
        pend_vld_q <= 1'b0;
      else if (pend_vld_q)
        sync_cnt_q <= sync_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      act_q <= {3{tccb_pkg::TCCB_VAL_RESET}};
    else if (do_update)
      act_q <= buf_i;
  end

  // rise seen on the synchronised level only, never on the raw first flop
  wire [1:0] pin_rise = pin_s2_q & ~pin_s3_q;
  wire [1:0] trig_d;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      assign trig_d[ch] = capture_channel_enable[ch] & (pin_capture_select[ch] ? pin_rise[ch] : capt_evt_i[ch]);
    end
  endgenerate

  // pin path: two flops then an edge detect on the synchronised level
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      trig_q <= 2'h0;
    end
    else
    begin
      pin_s1_q <= capt_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      trig_q <= trig_d;
    end
  end

  wire [31:0] stat_word = {28'h0000000, sync_busy, cap_mode, lock_eff, lock_q};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_q : (sel_stat ? stat_word : 32'h0000_0000);

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      wait_q <= ~req;
      if (req & avs_read_i)
        rdata_q <= rd_mux;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign active_o = act_q;
  assign update_lock_flag_o = lock_q;
  assign capture_channel_enable_o = capture_channel_enable;
  assign capt_trig_o = trig_q;
  assign enable_o = enabled;

  property p_update_copies;
    @(posedge mclk_i) disable iff (reset_i)
      (evt_i.upd && !(lock_q && !cap_mode)) |=> (active_o == $past(buf_i));
  endproperty
  a_update_copies: assert property (p_update_copies) else $error("update not copied");

  property p_lock_holds;
    @(posedge mclk_i) disable iff (reset_i)
      (evt_i.upd && lock_q && !cap_mode) |=> $stable(active_o);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked update changed values");

  property p_trig_src;
    @(posedge mclk_i) disable iff (reset_i)
      (capture_channel_enable[0] && !pin_capture_select[0] && capt_evt_i[0]) |=> capt_trig_o[0];
  endproperty
  a_trig_src: assert property (p_trig_src) else $error("event trigger lost");

  property p_compare_no_trig;
    @(posedge mclk_i) disable iff (reset_i)
      !capture_channel_enable[1] |=> !capt_trig_o[1];
  endproperty
  a_compare_no_trig: assert property (p_compare_no_trig) else $error("compare channel triggered");

  property p_capture_channel_enable_direct;
    @(posedge mclk_i) disable iff (reset_i)
      (wr_ctrl && !software_reset_trigger) |=> (capture_channel_enable_o == $past(avs_writedata_i[17:16]));
  endproperty
  a_capture_channel_enable_direct: assert property (p_capture_channel_enable_direct) else $error("capture_channel_enable not direct");

  property p_autolock;
    @(posedge mclk_i) disable iff (reset_i)
      (auto_lock_enable && (evt_i.ovf || evt_i.unf || evt_i.retrig) && !software_reset_trigger) |=> update_lock_flag_o;
  endproperty
  a_autolock: assert property (p_autolock) else $error("auto lock missed");

  property p_auto_lock_enable_direct;
    @(posedge mclk_i) disable iff (reset_i)
      (wr_ctrl && !software_reset_trigger) |=> (auto_lock_enable == $past(avs_writedata_i[11]));
  endproperty
  a_auto_lock_enable_direct: assert property (p_auto_lock_enable_direct) else $error("auto_lock_enable not direct");

  property p_capture_ignores_lock;
    @(posedge mclk_i) disable iff (reset_i)
      (evt_i.upd && cap_mode) |=> (active_o == $past(buf_i));
  endproperty
  a_capture_ignores_lock: assert property (p_capture_ignores_lock) else $error("lock used in capture");

  sequence s_write_enabled;
    wr_ctrl && enabled && !software_reset_trigger;
  endsequence
  property p_protected;
    @(posedge mclk_i) disable iff (reset_i)
      (s_write_enabled ##1 !wr_ctrl [*4]) |-> $stable(ctrl_q[21:20]);
  endproperty
  a_protected: assert property (p_protected) else $error("protected field changed");
endmodule

/* File: timer_capture_buffer_control_tb.sv */
// Purpose: self-checking bench for tccb_ctrl
// Assumes: answer to a request always comes; protected bits land after sync delay only while disabled
// Notes: model keeps lock flag, active values and direct bits
`timescale 1ns/1ps
module timer_capture_buffer_control_tb;
  logic mclk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  tccb_pkg::tccb_evt_t evt_i = '0;
  logic lock_set_i = 1'h0;
  logic lock_clr_i = 1'h0;
  tccb_pkg::tccb_vals_t buf_i = '0;
  tccb_pkg::tccb_vals_t active_o;
  logic [1:0] capt_evt_i = 2'h0;
  logic [1:0] capt_pin_i = 2'h0;
  logic [1:0] capture_channel_enable_o;
  logic [1:0] capt_trig_o;
  logic update_lock_flag_o;
  logic enable_o;
  int n_errors = 0;
  int tests_run = 0;
  logic [47:0] exp_act = 48'h0;
  logic exp_lock = 1'h0;
  logic exp_auto_lock_enable = 1'h0;
  logic exp_cap = 1'h0;
  logic [31:0] q;
  logic [1:0] seen;
  logic [63:0] r;
  int i;

  always #5 mclk_i = ~mclk_i;

  tccb_ctrl uut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .evt_i(evt_i),
    .lock_set_i(lock_set_i), .lock_clr_i(lock_clr_i), .buf_i(buf_i),
    .capt_evt_i(capt_evt_i), .capt_pin_i(capt_pin_i), .active_o(active_o),
    .update_lock_flag_o(update_lock_flag_o),
    .capture_channel_enable_o(capture_channel_enable_o),
    .capt_trig_o(capt_trig_o), .enable_o(enable_o));

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen_v, input logic [63:0] exp_v);
    tests_run++;
    if (seen_v !== exp_v)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen_v, exp_v);
    end
  endtask

  // fresh edge first, so a release and a new request never share a time step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge mclk_i);
      if (avs_waitrequest_o === 1'h0)
        break;
    end
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    q = avs_readdata_o;
    if (k == 20)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic lk(input logic s, input logic c);
    @(posedge mclk_i);
    lock_set_i <= s;
    lock_clr_i <= c;
    exp_lock = s | (exp_lock & !c);
    @(posedge mclk_i);
    lock_set_i <= 1'h0;
    lock_clr_i <= 1'h0;
  endtask

  // one counter event with fresh random buffers, then compare with the model
  task automatic evt(input logic [3:0] e);
    @(posedge mclk_i);
    r = {$urandom(), $urandom()};
    buf_i <= r[47:0];
    evt_i <= e;
    if (e[0] && (!exp_lock || exp_cap))
      exp_act = r[47:0];
    if (e[3:1] != 3'h0 && exp_auto_lock_enable)
      exp_lock = 1'h1;
    @(posedge mclk_i);
    evt_i <= '0;
    @(posedge mclk_i);
    chk(active_o, exp_act);
    chk(update_lock_flag_o, exp_lock);
  endtask

  task automatic watch(input int n);
    seen = 2'h0;
    repeat (n)
    begin
      @(posedge mclk_i);
      seen = seen | capt_trig_o;
    end
  endtask

  initial
  begin
    void'($urandom(32'h3be0443d));
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'h0;
    bus(1'h0, tccb_pkg::TCCB_OFF_CTRL, 32'h0);
    chk(q, tccb_pkg::TCCB_CTRL_RESET);
    bus(1'h1, 8'h08, 32'hffff_ffff);
    bus(1'h0, 8'h08, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, tccb_pkg::TCCB_OFF_CTRL, 32'h0000_0800);
    exp_auto_lock_enable = 1'h1;
    evt(4'h8);
    for (i = 1; i < 3; i++)
    begin
      lk(1'h0, 1'h1);
      evt(4'h8 >> i);
    end
    evt(4'h1);
    lk(1'h0, 1'h1);
    evt(4'h1);
    bus(1'h1, tccb_pkg::TCCB_OFF_CTRL, 32'h0003_0800);
    chk(capture_channel_enable_o, 2'h3);
    exp_cap = 1'h1;
    lk(1'h1, 1'h0);
    evt(4'h1);
    bus(1'h0, tccb_pkg::TCCB_OFF_STAT, 32'h0);
    chk(q, 32'h0000_0005);
    bus(1'h1, tccb_pkg::TCCB_OFF_CTRL, 32'h0013_0800);
    repeat (6) @(posedge mclk_i);
    @(posedge mclk_i);
    capt_evt_i <= 2'h3;
    @(posedge mclk_i);
    capt_evt_i <= 2'h0;
    watch(6);
    chk(seen, 2'h2);
    capt_pin_i <= 2'h1;
    watch(8);
    chk(seen, 2'h1);
    bus(1'h1, tccb_pkg::TCCB_OFF_CTRL, 32'h0000_0001);
    repeat (5) @(posedge mclk_i);
    chk(capture_channel_enable_o, 2'h0);
    bus(1'h1, tccb_pkg::TCCB_OFF_CTRL, 32'h0000_0002);
    repeat (5) @(posedge mclk_i);
    bus(1'h1, tccb_pkg::TCCB_OFF_CTRL, 32'h0010_0002);
    repeat (5) @(posedge mclk_i);
    bus(1'h0, tccb_pkg::TCCB_OFF_CTRL, 32'h0);
    chk(q, 32'h0000_0002);
    chk(enable_o, 1'h1);
    conclude();
  end
endmodule
